// *** adcts_defines.svh ***
`ifndef ADCTS_DEFINES_SVH
`define ADCTS_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADCTS_ADDR_W          8
`define ADCTS_DATA_W          32
`define ADCTS_OFS_SELECT      8'h00
`define ADCTS_OFS_STATUS      8'h04

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ADCTS_PRI_MSB         13
`define ADCTS_PRI_LSB         8
`define ADCTS_SEC_MSB         5
`define ADCTS_SEC_LSB         0
`define ADCTS_SELECT_RESET    16'h3f3f
`define ADCTS_ST_PRI_CNT_LSB  0
`define ADCTS_ST_SEC_CNT_LSB  8
`define ADCTS_ST_PRI_UNL      16
`define ADCTS_ST_SEC_UNL      17
`define ADCTS_ST_PRI_RETGT    18
`define ADCTS_ST_SEC_RETGT    19

// ----------------------------------------------------------------
// Trigger codes
// ----------------------------------------------------------------
`define ADCTS_C_NONE          6'h3f
`define ADCTS_C_PIN           6'h00
`define ADCTS_C_CH0_CMPA      6'h01
`define ADCTS_C_CH1_CMPA      6'h02
`define ADCTS_C_CH2_CMPA      6'h03
`define ADCTS_C_CH3_CMPA      6'h04
`define ADCTS_C_CH4_CMPA      6'h05
`define ADCTS_C_CH6_CMPA      6'h06
`define ADCTS_C_CH7_CMPA      6'h07
`define ADCTS_C_CH0_TRG       6'h08
`define ADCTS_C_CH4_A         6'h09
`define ADCTS_C_CH4_B         6'h0a
`define ADCTS_C_CH4_AORB      6'h0b
`define ADCTS_C_CH4_AB        6'h0c
`define ADCTS_C_CH7_A         6'h0d
`define ADCTS_C_CH7_B         6'h0e
`define ADCTS_C_CH7_AORB      6'h0f
`define ADCTS_C_CH7_AB        6'h10
`define ADCTS_C_CH9_CMPA      6'h13
`define ADCTS_C_CH9_TRG       6'h14
`define ADCTS_C_OR_0A_0T      6'h19
`define ADCTS_C_OR_9A_9T      6'h1a
`define ADCTS_C_OR_0A_9A      6'h1b
`define ADCTS_C_OR_0T_9T      6'h1c
`define ADCTS_C_BYTE0         6'h1d
`define ADCTS_C_BYTE1         6'h1e
`define ADCTS_C_BYTE2         6'h1f
`define ADCTS_C_BYTE3         6'h20
`define ADCTS_C_CH9_EXT       6'h21
`define ADCTS_C_CH0_EXT       6'h22
`define ADCTS_C_CH09_CMP      6'h23
`define ADCTS_C_CH09_TRG      6'h24
`define ADCTS_C_ELINK_1ST     6'h32
`define ADCTS_C_ELINK_2ND     6'h33
`define ADCTS_C_ELINK_OR      6'h3a

`endif

// *** adcts_pkg.sv ***
package adcts_pkg;

  typedef logic [5:0]  adcts_code_t;
  typedef logic [63:0] adcts_evt_vec_t;

  typedef enum logic [1:0]
  {
    ADCTS_REG_SELECT = 2'b00,
    ADCTS_REG_STATUS = 2'b01,
    ADCTS_REG_NONE   = 2'b10
  } adcts_reg_t;

endpackage

// *** adcts_pin_sync.sv ***
`include "adcts_defines.svh"

module adcts_pin_sync
  import adcts_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Asynchronous active-low pin
  input  wire logic pin_n,
  // One-cycle pulse on the asserting edge
  output logic      fallPulse
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // Idle level is high so that leaving reset with the pin idle never looks like an edge
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin_n;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign fallPulse = last_q & ~sync_q;

endmodule

// *** adcts_trigger_mux.sv ***
`include "adcts_defines.svh"

module adcts_trigger_mux
  import adcts_pkg::*;
(
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // Selection and candidate events, indexed by code
  input  wire adcts_code_t    code,
  input  wire adcts_evt_vec_t events,
  // Registered start request
  output logic                scanStart
);

  logic scanStart_q;
  logic scanStart_d;

  // Unlisted codes have a zero entry, so they never start a scan
  assign scanStart_d = events[code];

  always_ff @(posedge clock)
  begin
    if (rst)
      scanStart_q <= 1'b0;
    else
      scanStart_q <= scanStart_d;
  end

  assign scanStart = scanStart_q;

endmodule

// *** adcts_trigger_select.sv ***
// Behaviour
// - Primary code lives in bits 13..8
// - Secondary code lives in bits 5..0
// - All-ones code disables that group
// - Primary code zero selects external pin
// - Codes 1-5, 8-12 pick base timer events
// - Extended codes 6,7,13-16 pick channels 6 and 7
// - Extended channel 9 and OR pair codes
// - Extended codes 33-36 pick extra timer events
// - Codes 29,30 (ext 31,32) pick byte timers
// - Extended codes 50,51 pick event-link triggers
// - Extended code 58 ORs both event-link triggers
`include "adcts_defines.svh"

module adcts_trigger_select
  import adcts_pkg::*;
#(
  parameter bit EXTENDED = 1'b1
)
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Register port
  input  wire logic [`ADCTS_ADDR_W-1:0] address,
  input  wire logic [`ADCTS_DATA_W-1:0] writeData,
  input  wire logic                     writeStrobe,
  input  wire logic                     readStrobe,
  output logic      [`ADCTS_DATA_W-1:0] readData,
  // External pin
  input  wire logic                     externalConvStartPin_n,
  // Multi-function timer events
  input  wire logic                     timerCh0CompareAEvt,
  input  wire logic                     timerCh1CompareAEvt,
  input  wire logic                     timerCh2CompareAEvt,
  input  wire logic                     timerCh3CompareAEvt,
  input  wire logic                     timerCh4CompareAEvt,
  input  wire logic                     timerCh6CompareAEvt,
  input  wire logic                     timerCh7CompareAEvt,
  input  wire logic                     timerCh0TriggerEvt,
  input  wire logic                     timerCh4AEvt,
  input  wire logic                     timerCh4BEvt,
  input  wire logic                     timerCh4CombinedEvt,
  input  wire logic                     timerCh7AEvt,
  input  wire logic                     timerCh7BEvt,
  input  wire logic                     timerCh7CombinedEvt,
  input  wire logic                     timerCh9CompareAEvt,
  input  wire logic                     timerCh9TriggerEvt,
  input  wire logic                     timerCh9ExtendedEvt,
  input  wire logic                     timerCh0ExtendedEvt,
  input  wire logic                     timerCh09CompareEvt,
  input  wire logic                     timerCh09TriggerEvt,
  // Eight-bit timer events
  input  wire logic                     byteTimerUnit0CompareEvt,
  input  wire logic                     byteTimerUnit1CompareEvt,
  input  wire logic                     byteTimerUnit2CompareEvt,
  input  wire logic                     byteTimerUnit3CompareEvt,
  // Event-link triggers for this unit
  input  wire logic                     eventLinkTriggerFirst,
  input  wire logic                     eventLinkTriggerSecond,
  // Scan starts toward the sequencer
  output logic                          primaryScanStart,
  output logic                          secondaryScanStart
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // A code is listed when its slot in the event table can ever fire, or when it is the deselect code
  function automatic logic codeListed(input adcts_evt_vec_t tbl, input adcts_code_t c);
    codeListed = tbl[c];
  endfunction

  // Counter that sticks at its top value instead of wrapping
  function automatic logic [7:0] satInc(input logic [7:0] v, input logic hit);
    if (hit && (v != 8'hff))
      satInc = v + 8'h01;
    else
      satInc = v;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic pinPulse;

  adcts_pin_sync u_pin_sync
  (
    .clock     (clock),
    .rst       (rst),
    .pin_n     (externalConvStartPin_n),
    .fallPulse (pinPulse)
  );

  // ----------------------------------------------------------------
  // Event table, one slot per code
  // ----------------------------------------------------------------
  wire logic ext = EXTENDED;
  adcts_evt_vec_t secEvents;
  adcts_evt_vec_t priEvents;
  adcts_evt_vec_t listedMask;

  always_comb
  begin
    secEvents = '0;
    // Base timer selections
    secEvents[`ADCTS_C_CH0_CMPA]  = timerCh0CompareAEvt;
    secEvents[`ADCTS_C_CH1_CMPA]  = timerCh1CompareAEvt;
    secEvents[`ADCTS_C_CH2_CMPA]  = timerCh2CompareAEvt;
    secEvents[`ADCTS_C_CH3_CMPA]  = timerCh3CompareAEvt;
    secEvents[`ADCTS_C_CH4_CMPA]  = timerCh4CompareAEvt;
    secEvents[`ADCTS_C_CH0_TRG]   = timerCh0TriggerEvt;
    secEvents[`ADCTS_C_CH4_A]     = timerCh4AEvt;
    secEvents[`ADCTS_C_CH4_B]     = timerCh4BEvt;
    secEvents[`ADCTS_C_CH4_AORB]  = timerCh4AEvt | timerCh4BEvt;
    secEvents[`ADCTS_C_CH4_AB]    = timerCh4CombinedEvt;
    // Channel 6 and 7
    secEvents[`ADCTS_C_CH6_CMPA]  = ext & timerCh6CompareAEvt;
    secEvents[`ADCTS_C_CH7_CMPA]  = ext & timerCh7CompareAEvt;
    secEvents[`ADCTS_C_CH7_A]     = ext & timerCh7AEvt;
    secEvents[`ADCTS_C_CH7_B]     = ext & timerCh7BEvt;
    secEvents[`ADCTS_C_CH7_AORB]  = ext & (timerCh7AEvt | timerCh7BEvt);
    secEvents[`ADCTS_C_CH7_AB]    = ext & timerCh7CombinedEvt;
    // Channel 9 and OR pairs of channels 0 and 9
    secEvents[`ADCTS_C_CH9_CMPA]  = ext & timerCh9CompareAEvt;
    secEvents[`ADCTS_C_CH9_TRG]   = ext & timerCh9TriggerEvt;
    secEvents[`ADCTS_C_OR_0A_0T]  = ext & (timerCh0CompareAEvt | timerCh0TriggerEvt);
    secEvents[`ADCTS_C_OR_9A_9T]  = ext & (timerCh9CompareAEvt | timerCh9TriggerEvt);
    secEvents[`ADCTS_C_OR_0A_9A]  = ext & (timerCh0CompareAEvt | timerCh9CompareAEvt);
    secEvents[`ADCTS_C_OR_0T_9T]  = ext & (timerCh0TriggerEvt | timerCh9TriggerEvt);
    // Additional timer-derived events
    secEvents[`ADCTS_C_CH9_EXT]   = ext & timerCh9ExtendedEvt;
    secEvents[`ADCTS_C_CH0_EXT]   = ext & timerCh0ExtendedEvt;
    secEvents[`ADCTS_C_CH09_CMP]  = ext & timerCh09CompareEvt;
    secEvents[`ADCTS_C_CH09_TRG]  = ext & timerCh09TriggerEvt;
    // Eight-bit timers
    secEvents[`ADCTS_C_BYTE0]     = byteTimerUnit0CompareEvt;
    secEvents[`ADCTS_C_BYTE1]     = byteTimerUnit1CompareEvt;
    secEvents[`ADCTS_C_BYTE2]     = ext & byteTimerUnit2CompareEvt;
    secEvents[`ADCTS_C_BYTE3]     = ext & byteTimerUnit3CompareEvt;
    // Event-link pair of this unit
    secEvents[`ADCTS_C_ELINK_1ST] = ext & eventLinkTriggerFirst;
    secEvents[`ADCTS_C_ELINK_2ND] = ext & eventLinkTriggerSecond;
    secEvents[`ADCTS_C_ELINK_OR]  = ext & (eventLinkTriggerFirst | eventLinkTriggerSecond);
    // The deselect slot stays zero for both groups
    secEvents[`ADCTS_C_NONE]      = 1'b0;
  end

  // Only the primary group reaches the pin; code zero is dead for the secondary
  always_comb
  begin
    priEvents = secEvents;
    priEvents[`ADCTS_C_PIN] = pinPulse;
  end

  // Which codes are listed, independent of current event activity
  always_comb
  begin
    listedMask = '0;
    listedMask[`ADCTS_C_CH4_CMPA:`ADCTS_C_CH0_CMPA] = 5'h1f;
    listedMask[`ADCTS_C_CH4_AB:`ADCTS_C_CH0_TRG]    = 5'h1f;
    listedMask[`ADCTS_C_BYTE1:`ADCTS_C_BYTE0]       = 2'h3;
    listedMask[`ADCTS_C_NONE]                       = 1'b1;
    if (ext)
    begin
      listedMask[`ADCTS_C_CH7_CMPA:`ADCTS_C_CH6_CMPA] = 2'h3;
      listedMask[`ADCTS_C_CH7_AB:`ADCTS_C_CH7_A]      = 4'hf;
      listedMask[`ADCTS_C_CH9_TRG:`ADCTS_C_CH9_CMPA]  = 2'h3;
      listedMask[`ADCTS_C_OR_0T_9T:`ADCTS_C_OR_0A_0T] = 4'hf;
      listedMask[`ADCTS_C_CH09_TRG:`ADCTS_C_BYTE2]    = 6'h3f;
      listedMask[`ADCTS_C_ELINK_2ND:`ADCTS_C_ELINK_1ST] = 2'h3;
      listedMask[`ADCTS_C_ELINK_OR]                   = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  adcts_reg_t regSel;
  wire logic  selectHit = (address == `ADCTS_OFS_SELECT);
  wire logic  statusHit = (address == `ADCTS_OFS_STATUS);

  assign regSel = selectHit ? ADCTS_REG_SELECT :
                  statusHit ? ADCTS_REG_STATUS : ADCTS_REG_NONE;

  wire logic        selectWrite = writeStrobe & (regSel == ADCTS_REG_SELECT);
  wire logic        statusWrite = writeStrobe & (regSel == ADCTS_REG_STATUS);
  wire adcts_code_t newPri      = writeData[`ADCTS_PRI_MSB:`ADCTS_PRI_LSB];
  wire adcts_code_t newSec      = writeData[`ADCTS_SEC_MSB:`ADCTS_SEC_LSB];

  // ----------------------------------------------------------------
  // Trigger select register
  // ----------------------------------------------------------------
  adcts_code_t priCode_q;
  adcts_code_t secCode_q;
  logic [15:0] selectReset;

  assign selectReset = `ADCTS_SELECT_RESET;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      priCode_q <= selectReset[`ADCTS_PRI_MSB:`ADCTS_PRI_LSB];
      secCode_q <= selectReset[`ADCTS_SEC_MSB:`ADCTS_SEC_LSB];
    end
    else if (selectWrite)
    begin
      priCode_q <= newPri;
      secCode_q <= newSec;
    end
  end

  // ----------------------------------------------------------------
  // Group selectors
  // ----------------------------------------------------------------
  adcts_trigger_mux u_pri_mux
  (
    .clock     (clock),
    .rst       (rst),
    .code      (priCode_q),
    .events    (priEvents),
    .scanStart (primaryScanStart)
  );

  adcts_trigger_mux u_sec_mux
  (
    .clock     (clock),
    .rst       (rst),
    .code      (secCode_q),
    .events    (secEvents),
    .scanStart (secondaryScanStart)
  );

  // ----------------------------------------------------------------
  // Status: start counts, unlisted codes, unsafe source changes
  // ----------------------------------------------------------------
  logic [7:0] priCount_q;
  logic [7:0] secCount_q;
  logic       priRetarget_q;
  logic       secRetarget_q;
  adcts_evt_vec_t priListed;

  // Pin code is listed for the primary group only
  always_comb
  begin
    priListed = listedMask;
    priListed[`ADCTS_C_PIN] = 1'b1;
  end

  wire logic priUnlisted = ~codeListed(priListed, priCode_q);
  wire logic secUnlisted = ~codeListed(listedMask, secCode_q);

  // A live source swapped for another live source skipped the deselect step
  wire logic priSwap = selectWrite & (newPri != priCode_q) &
                       (newPri != `ADCTS_C_NONE) & (priCode_q != `ADCTS_C_NONE);
  wire logic secSwap = selectWrite & (newSec != secCode_q) &
                       (newSec != `ADCTS_C_NONE) & (secCode_q != `ADCTS_C_NONE);
  wire logic priRetClr = statusWrite & writeData[`ADCTS_ST_PRI_RETGT];
  wire logic secRetClr = statusWrite & writeData[`ADCTS_ST_SEC_RETGT];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      priCount_q    <= 8'h00;
      secCount_q    <= 8'h00;
      priRetarget_q <= 1'b0;
      secRetarget_q <= 1'b0;
    end
    else
    begin
      priCount_q    <= satInc(priCount_q, primaryScanStart);
      secCount_q    <= satInc(secCount_q, secondaryScanStart);
      // Set beats the write-one clear in the same cycle
      priRetarget_q <= priSwap | (priRetarget_q & ~priRetClr);
      secRetarget_q <= secSwap | (secRetarget_q & ~secRetClr);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [`ADCTS_DATA_W-1:0] readData_q;
  logic [`ADCTS_DATA_W-1:0] readMux;
  logic [`ADCTS_DATA_W-1:0] selectView;
  logic [`ADCTS_DATA_W-1:0] statusView;

  always_comb
  begin
    selectView = '0;
    selectView[`ADCTS_PRI_MSB:`ADCTS_PRI_LSB] = priCode_q;
    selectView[`ADCTS_SEC_MSB:`ADCTS_SEC_LSB] = secCode_q;
    statusView = '0;
    statusView[`ADCTS_ST_PRI_CNT_LSB +: 8] = priCount_q;
    statusView[`ADCTS_ST_SEC_CNT_LSB +: 8] = secCount_q;
    statusView[`ADCTS_ST_PRI_UNL]          = priUnlisted;
    statusView[`ADCTS_ST_SEC_UNL]          = secUnlisted;
    statusView[`ADCTS_ST_PRI_RETGT]        = priRetarget_q;
    statusView[`ADCTS_ST_SEC_RETGT]        = secRetarget_q;
  end

  // Unmapped addresses read zero
  assign readMux = (regSel == ADCTS_REG_SELECT) ? selectView :
                   (regSel == ADCTS_REG_STATUS) ? statusView : '0;

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock)
  begin
    if (rst)
      readData_q <= '0;
    else if (readStrobe)
      readData_q <= readMux;
    else
      readData_q <= '0;
  end

  assign readData = readData_q;

endmodule

// *** adcts_seq_model.sv ***
module adcts_seq_model
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Start requests from the selector
  input  wire logic       primaryScanStart,
  input  wire logic       secondaryScanStart,
  // Scans begun so far, wrapping
  output logic      [7:0] priScans,
  output logic      [7:0] secScans
);
  timeunit 1ns;
  timeprecision 1ps;

  // Each start cycle begins one scan of its group
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      priScans <= 8'h00;
      secScans <= 8'h00;
    end
    else
    begin
      priScans <= priScans + {7'h00, primaryScanStart};
      secScans <= secScans + {7'h00, secondaryScanStart};
    end
  end
endmodule

// *** adcts_trigger_select_chk.sv ***
`include "adcts_defines.svh"

module adcts_trigger_select_chk
  import adcts_pkg::*;
(
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // Register port
  input wire logic [`ADCTS_ADDR_W-1:0] address,
  input wire logic [`ADCTS_DATA_W-1:0] writeData,
  input wire logic                     writeStrobe,
  input wire logic                     readStrobe,
  input wire logic [`ADCTS_DATA_W-1:0] readData,
  // Sources
  input wire logic                     externalConvStartPin_n,
  input wire logic                     timerCh0CompareAEvt,
  input wire logic                     byteTimerUnit0CompareEvt,
  input wire logic                     eventLinkTriggerFirst,
  input wire logic                     eventLinkTriggerSecond,
  // Starts
  input wire logic                     primaryScanStart,
  input wire logic                     secondaryScanStart
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------
  // Shadow of the stored codes
  // --------------------------------
  adcts_code_t priCode_q;
  adcts_code_t secCode_q;
  wire         selWrite = writeStrobe && (address == `ADCTS_OFS_SELECT);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      priCode_q <= `ADCTS_C_NONE;
      secCode_q <= `ADCTS_C_NONE;
    end
    else if (selWrite)
    begin
      priCode_q <= writeData[`ADCTS_PRI_MSB:`ADCTS_PRI_LSB];
      secCode_q <= writeData[`ADCTS_SEC_MSB:`ADCTS_SEC_LSB];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_idle_read_zero:
    assert property (!readStrobe |=> readData == '0)
    else $error("read data not zero outside read");
  a_select_readback:
    assert property (readStrobe && address == `ADCTS_OFS_SELECT |=>
      readData == {18'h0, $past(priCode_q), 2'h0, $past(secCode_q)})
    else $error("select readback mismatch");
  a_unmapped_read_zero:
    assert property (readStrobe && address != `ADCTS_OFS_SELECT &&
      address != `ADCTS_OFS_STATUS |=> readData == '0)
    else $error("unmapped read not zero");
  a_pri_none_quiet:
    assert property (priCode_q == `ADCTS_C_NONE |=> !primaryScanStart)
    else $error("primary start while deselected");
  a_sec_none_quiet:
    assert property (secCode_q == `ADCTS_C_NONE |=> !secondaryScanStart)
    else $error("secondary start while deselected");
  a_sec_zero_quiet:
    assert property (secCode_q == `ADCTS_C_PIN |=> !secondaryScanStart)
    else $error("secondary start on code zero");
  a_ch0_pri_start:
    assert property (priCode_q == `ADCTS_C_CH0_CMPA && timerCh0CompareAEvt
      |=> primaryScanStart)
    else $error("primary start missing for channel 0");
  a_byte0_sec_start:
    assert property (secCode_q == `ADCTS_C_BYTE0 && byteTimerUnit0CompareEvt
      |=> secondaryScanStart)
    else $error("secondary start missing for byte timer");
  a_elink_or_start:
    assert property (secCode_q == `ADCTS_C_ELINK_OR &&
      (eventLinkTriggerFirst || eventLinkTriggerSecond) |=> secondaryScanStart)
    else $error("secondary start missing for event link pair");
  a_pin_start:
    assert property (priCode_q == `ADCTS_C_PIN && $fell(externalConvStartPin_n)
      |-> ##[2:6] primaryScanStart)
    else $error("primary start missing after pin fall");
endmodule

bind adcts_trigger_select adcts_trigger_select_chk u_chk (.*);

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock, rst, wrS, rdS, pinN, priStart, secStart;
  logic [7:0]  addr, priScans, secScans;
  logic [31:0] wData, rData;
  logic [25:0] ev;
  int          errCount, numChecks;

  // Entry: code, first source index, second source index
  localparam logic [17:0] TBL [33] = '{
    18'h01000, 18'h02041, 18'h03082, 18'h040c3, 18'h05104, 18'h06145,
    18'h07186, 18'h081c7, 18'h09208, 18'h0a249, 18'h0c28a, 18'h0d2cb,
    18'h0e30c, 18'h1034d, 18'h1338e, 18'h143cf, 18'h21410, 18'h22451,
    18'h23492, 18'h244d3, 18'h1d514, 18'h1e555, 18'h1f596, 18'h205d7,
    18'h32618, 18'h33659, 18'h0b209, 18'h0f2cc, 18'h19007, 18'h1a38f,
    18'h1b00e, 18'h1c1cf, 18'h3a619};

  adcts_trigger_select DUT (
    .clock(clock), .rst(rst), .address(addr), .writeData(wData),
    .writeStrobe(wrS), .readStrobe(rdS), .readData(rData),
    .externalConvStartPin_n(pinN),
    .timerCh0CompareAEvt(ev[0]), .timerCh1CompareAEvt(ev[1]),
    .timerCh2CompareAEvt(ev[2]), .timerCh3CompareAEvt(ev[3]),
    .timerCh4CompareAEvt(ev[4]), .timerCh6CompareAEvt(ev[5]),
    .timerCh7CompareAEvt(ev[6]), .timerCh0TriggerEvt(ev[7]),
    .timerCh4AEvt(ev[8]), .timerCh4BEvt(ev[9]), .timerCh4CombinedEvt(ev[10]),
    .timerCh7AEvt(ev[11]), .timerCh7BEvt(ev[12]), .timerCh7CombinedEvt(ev[13]),
    .timerCh9CompareAEvt(ev[14]), .timerCh9TriggerEvt(ev[15]),
    .timerCh9ExtendedEvt(ev[16]), .timerCh0ExtendedEvt(ev[17]),
    .timerCh09CompareEvt(ev[18]), .timerCh09TriggerEvt(ev[19]),
    .byteTimerUnit0CompareEvt(ev[20]), .byteTimerUnit1CompareEvt(ev[21]),
    .byteTimerUnit2CompareEvt(ev[22]), .byteTimerUnit3CompareEvt(ev[23]),
    .eventLinkTriggerFirst(ev[24]), .eventLinkTriggerSecond(ev[25]),
    .primaryScanStart(priStart), .secondaryScanStart(secStart));

  adcts_seq_model u_seq (.clock(clock), .rst(rst), .primaryScanStart(priStart),
    .secondaryScanStart(secStart), .priScans(priScans), .secScans(secScans));

  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wData <= d;
    wrS   <= 1'b1;
    @(posedge clock);
    wrS <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rdS  <= 1'b1;
    @(posedge clock);
    rdS <= 1'b0;
    #1;
    chk("readData", e, rData);
  endtask

  task automatic fire(logic [25:0] m, logic eP, logic eS);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= '0;
    #1;
    chk("primaryScanStart", {31'h0, eP}, {31'h0, priStart});
    chk("secondaryScanStart", {31'h0, eS}, {31'h0, secStart});
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic testReset();
    rd(8'h00, 32'h00003f3f);
    fire('1, 1'b0, 1'b0);
  endtask

  // Bits outside both fields are set and must read back as zero
  task automatic testFields();
    wr(8'h00, 32'hffffdedd);
    rd(8'h00, 32'h00001e1d);
    fire(26'd1 << 21, 1'b1, 1'b0);
    fire(26'd1 << 20, 1'b0, 1'b1);
    wr(8'h00, 32'h00003f3f);
  endtask

  // A live-to-live swap raises the status flags; writing ones clears them
  task automatic testUnlisted();
    wr(8'h00, 32'h00001100);
    fire('1, 1'b0, 1'b0);
    wr(8'h08, 32'h00000101);
    rd(8'h00, 32'h00001100);
    rd(8'h08, 32'h00000000);
    rd(8'h04, 32'h00030101);
    wr(8'h00, 32'h00000102);
    rd(8'h04, 32'h000c0101);
    wr(8'h04, 32'h000c0000);
    rd(8'h04, 32'h00000101);
    wr(8'h00, 32'h00003f3f);
  endtask

  task automatic testPin();
    logic [7:0] p, s;
    wr(8'h00, 32'h00000000);
    p = priScans;
    s = secScans;
    @(posedge clock);
    pinN <= 1'b0;
    repeat (8) @(posedge clock);
    pinN <= 1'b1;
    repeat (8) @(posedge clock);
    chk("priScans", 32'h1, {24'h0, priScans - p});
    chk("secScans", 32'h0, {24'h0, secScans - s});
    wr(8'h00, 32'h00003f3f);
  endtask

  // An event held three cycles gives three starts
  task automatic testBurst();
    logic [7:0] p;
    wr(8'h00, 32'h0000013f);
    p = priScans;
    @(posedge clock);
    ev <= 26'd1;
    repeat (3) @(posedge clock);
    ev <= '0;
    repeat (3) @(posedge clock);
    chk("priScans", 32'h3, {24'h0, priScans - p});
    wr(8'h00, 32'h00003f3f);
  endtask

  task automatic testTable();
    logic [5:0] c, a, b;
    for (int i = 0; i < 33; i++)
    begin
      c = TBL[i][17:12];
      a = TBL[i][11:6];
      b = TBL[i][5:0];
      wr(8'h00, {18'h0, c, 2'h0, c});
      fire(26'd1 << a, 1'b1, 1'b1);
      fire(26'd1 << b, 1'b1, 1'b1);
      fire(~((26'd1 << a) | (26'd1 << b)), 1'b0, 1'b0);
      wr(8'h00, 32'h00003f3f);
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    #100us;
    errCount++;
    tallyAndFinish();
  end

  initial
  begin
    errCount  = 0;
    numChecks = 0;
    rst   = 1'b1;
    wrS   = 1'b0;
    rdS   = 1'b0;
    addr  = 8'h00;
    wData = 32'h0;
    ev    = '0;
    pinN  = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    testReset();
    testFields();
    testUnlisted();
    testPin();
    testBurst();
    testTable();
    tallyAndFinish();
  end
endmodule
